// >>> osc_analog_model.sv
// oscillator stand-in: comparator levels follow the trims applied to it.
// assumes trims come straight from the control block's registered outputs.
`timescale 1ns/10ps
`default_nettype none
module osc_analog_model #(
    parameter logic [3:0] CUR_OK  = 4'h9,  // lowest current with good swing
    parameter logic [2:0] BANK_OK = 3'h5,  // bank that lands on the target
    parameter logic [7:0] DEV_OK  = 8'h5A  // deviation trim giving the target
) (
    input  wire logic       i_lock_en,     // bench lets the loop lock or not
    input  wire logic [3:0] i_cur,
    input  wire logic [2:0] i_bank,
    input  wire logic [7:0] i_dev,
    output logic            o_amp_ok,
    output logic            o_freq_high,
    output logic            o_pll_lock,
    output logic            o_dev_high
);
    // ideal comparators, so every search has one right answer
    assign o_amp_ok    = (i_cur >= CUR_OK);
    assign o_freq_high = (i_bank > BANK_OK);
    assign o_dev_high  = (i_dev > DEV_OK);
    assign o_pll_lock  = i_lock_en;
endmodule
`default_nettype wire

// >>> osc_cal_engine.sv
// oscillator current, bank and deviation calibration sequencer.
// assumes the analog comparators are stable after each settle interval.
`timescale 1ns/10ps
`default_nettype none
`include "synth_defs.svh"
module osc_cal_engine #(
    parameter int CUR_SETTLE  = `US_TO_CYCLES(`CUR_SETTLE_US),
    parameter int BAND_SETTLE = `US_TO_CYCLES(`PLL_SETTLE_US),
    parameter int DEV_SETTLE  = `US_TO_CYCLES(`DEV_SETTLE_US)
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_pll_on,      // pll and oscillator powered
    input  wire logic [2:0] i_req,         // {current, bank, deviation} start bits
    input  wire logic       i_amp_ok,      // oscillator amplitude adequate
    input  wire logic       i_freq_high,   // oscillator above target with trial bank
    input  wire logic       i_pll_lock,    // pll locked
    input  wire logic       i_dev_high,    // deviation above target
    output logic            o_busy,
    output logic [3:0]      o_cur_trial,
    output logic [2:0]      o_band_trial,
    output logic [7:0]      o_dev_trial,
    output logic [2:0]      o_done,        // one-cycle {current, bank, deviation}
    output logic [3:0]      o_cur_result,
    output logic            o_cur_fail,
    output logic [2:0]      o_band_result,
    output logic            o_band_fail,
    output logic [7:0]      o_dev_result
);
    synth_pkg::cal_state_type q, d;   // registered state and its next value

    localparam logic [15:0] CUR_RELOAD  = 16'(CUR_SETTLE - 1);
    localparam logic [15:0] BAND_RELOAD = 16'(BAND_SETTLE - 1);
    localparam logic [15:0] DEV_RELOAD  = 16'(DEV_SETTLE - 1);

    logic [2:0] pend;                 // start bits still wanting a run

    // a done pulse means its start bit clears next edge; without this mask the
    // finished item would be picked up again in that one stale cycle
    assign pend = i_req & ~q.done;

    // next state: one item at a time, current first because bank depends on it
    always_comb begin
        d = q;
        d.done = 3'b000;
        case (q.state)
            synth_pkg::CAL_IDLE: begin
                // a start bit set outside pll mode waits until pll mode arrives
                if (i_pll_on && pend[2]) begin
                    d.state = synth_pkg::CAL_CUR;
                    d.cur   = 4'h0;
                    d.cnt   = CUR_RELOAD;
                end else if (i_pll_on && pend[1]) begin
                    d.state = synth_pkg::CAL_BAND;
                    d.band  = 3'b100;
                    d.step  = 3'd0;
                    d.cnt   = BAND_RELOAD;
                end else if (i_pll_on && pend[0]) begin
                    d.state = synth_pkg::CAL_DEV;
                    d.dev   = 8'h80;
                    d.step  = 3'd0;
                    d.cnt   = DEV_RELOAD;
                end
            end
            synth_pkg::CAL_CUR: begin
                // ramp current up until the amplitude detector is satisfied
                if (q.cnt != 16'h0000) begin
                    d.cnt = q.cnt - 16'h0001;
                end else if (i_amp_ok || q.cur == `CUR_MAX) begin
                    d.cur_res  = q.cur;
                    d.cur_fail = ~i_amp_ok;
                    d.done[2]  = 1'b1;
                    d.state    = synth_pkg::CAL_IDLE;
                end else begin
                    d.cur = q.cur + 4'h1;
                    d.cnt = CUR_RELOAD;
                end
            end
            synth_pkg::CAL_BAND: begin
                // three search steps plus one lock check: four settle intervals
                if (q.cnt != 16'h0000) begin
                    d.cnt = q.cnt - 16'h0001;
                end else if (q.step == `BAND_LAST_STEP) begin
                    d.band_res  = q.band;
                    d.band_fail = ~i_pll_lock;
                    d.done[1]   = 1'b1;
                    d.state     = synth_pkg::CAL_IDLE;
                end else begin
                    if (i_freq_high)
                        d.band[2'(2 - q.step)] = 1'b0;
                    if (q.step != 3'd2)
                        d.band[2'(1 - q.step)] = 1'b1;
                    d.step = q.step + 3'd1;
                    d.cnt  = BAND_RELOAD;
                end
            end
            synth_pkg::CAL_DEV: begin
                // successive approximation against the 500 kHz deviation target
                if (q.cnt != 16'h0000) begin
                    d.cnt = q.cnt - 16'h0001;
                end else begin
                    if (i_dev_high)
                        d.dev[3'(7 - q.step)] = 1'b0;
                    if (q.step == `DEV_LAST_STEP) begin
                        d.dev_res = i_dev_high ? {q.dev[7:1], 1'b0} : q.dev;
                        d.done[0] = 1'b1;
                        d.state   = synth_pkg::CAL_IDLE;
                    end else begin
                        d.dev[3'(6 - q.step)] = 1'b1;
                        d.step = q.step + 3'd1;
                        d.cnt  = DEV_RELOAD;
                    end
                end
            end
            default: d.state = synth_pkg::CAL_IDLE;
        endcase
        // losing pll mode aborts; the start bit stays set and retries later
        if (!i_pll_on && q.state != synth_pkg::CAL_IDLE)
            d.state = synth_pkg::CAL_IDLE;
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q       <= '0;
            q.state <= synth_pkg::CAL_IDLE;
            q.dev_res <= `RST_OSC_DEV_CAL;
        end else begin
            q <= d;
        end
    end

    assign o_busy        = (q.state != synth_pkg::CAL_IDLE);
    assign o_cur_trial   = q.cur;
    assign o_band_trial  = q.band;
    assign o_dev_trial   = q.dev;
    assign o_done        = q.done;
    assign o_cur_result  = q.cur_res;
    assign o_cur_fail    = q.cur_fail;
    assign o_band_result = q.band_res;
    assign o_band_fail   = q.band_fail;
    assign o_dev_result  = q.dev_res;
endmodule
`default_nettype wire

// >>> synth_ctrl.sv
// synthesiser tuning arithmetic, register file and calibration control.
// assumes the serial port is already decoded into byte-wide register
// accesses and strobe bytes, synchronous to i_clk.
//
// Overview of operation
// - base frequency from comparison frequency and multipliers
// - band factor 2, 4 or 6 by code
// - offset is channel number times channel step
// - carrier is base over band plus offset
// - start bits run calibrations, then self clear
// - current pass/fail flag and four-bit result readable
// - bank calibration picks bank, flag and result
// - bank calibration ends within about 240 us
// - deviation calibration trims toward 500 kHz
// - deviation result readable, no pass/fail flag
// - pll strobe nibble 1011 enters pll mode
`timescale 1ns/10ps
`default_nettype none
`include "synth_defs.svh"
module synth_ctrl #(
    parameter int XTAL_HZ     = 16000000,                         // crystal frequency
    parameter int CUR_SETTLE  = `US_TO_CYCLES(`CUR_SETTLE_US),   // current step settle
    parameter int BAND_SETTLE = `US_TO_CYCLES(`PLL_SETTLE_US),   // pll settle, per bank step
    parameter int DEV_SETTLE  = `US_TO_CYCLES(`DEV_SETTLE_US)    // deviation step settle
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_reg_wr,         // register write strobe
    input  wire logic        i_reg_rd,         // register read strobe
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    input  wire logic        i_strobe_valid,   // strobe command byte present
    input  wire logic [7:0]  i_strobe_cmd,
    input  wire logic        i_amp_ok,
    input  wire logic        i_freq_high,
    input  wire logic        i_pll_lock,
    input  wire logic        i_dev_high,
    output logic             o_pll_on,
    output logic             o_cal_busy,
    output logic      [3:0]  o_vco_current,
    output logic      [2:0]  o_vco_bank,
    output logic      [7:0]  o_vco_dev,
    output logic      [31:0] o_comparison_freq,
    output logic      [31:0] o_base_osc_freq,
    output logic      [31:0] o_band_freq,
    output logic      [31:0] o_channel_step,
    output logic      [31:0] o_carrier_freq
);
    synth_pkg::ctrl_state_type q, d;   // registered state and its next value

    logic       busy;                   // calibration in progress
    logic [3:0] cur_trial;              // engine trial values
    logic [2:0] band_trial;
    logic [7:0] dev_trial;
    logic [2:0] done;                   // per-item completion pulses
    logic [3:0] cur_res;
    logic       cur_fail;
    logic [2:0] band_res;
    logic       band_fail;
    logic [7:0] dev_res;

    // one write-address decode, shared by every register
    function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] o);
        wr_hit = wr && (a == o);
    endfunction

    // division factor for a band select code
    function automatic logic [63:0] band_factor(input logic [1:0] code);
        case (code)
            2'b10, 2'b11: band_factor = `BAND_FACTOR_HI;
            2'b01:        band_factor = `BAND_FACTOR_MID;
            default:      band_factor = `BAND_FACTOR_LO;
        endcase
    endfunction

    osc_cal_engine #(
        .CUR_SETTLE  (CUR_SETTLE),
        .BAND_SETTLE (BAND_SETTLE),
        .DEV_SETTLE  (DEV_SETTLE)
    ) u_cal (
        .i_clk         (i_clk),
        .i_rst_n       (i_rst_n),
        .i_pll_on      (q.pll_on),
        .i_req         (q.start),
        .i_amp_ok      (i_amp_ok),
        .i_freq_high   (i_freq_high),
        .i_pll_lock    (i_pll_lock),
        .i_dev_high    (i_dev_high),
        .o_busy        (busy),
        .o_cur_trial   (cur_trial),
        .o_band_trial  (band_trial),
        .o_dev_trial   (dev_trial),
        .o_done        (done),
        .o_cur_result  (cur_res),
        .o_cur_fail    (cur_fail),
        .o_band_result (band_res),
        .o_band_fail   (band_fail),
        .o_dev_result  (dev_res)
    );

    // next state: registers, strobes, applied trims and frequency words
    always_comb begin
        logic [63:0] xtal_scaled;   // crystal times doubler factor
        logic [63:0] cmp_full;      // comparison frequency
        logic [63:0] mult_full;     // integer and fraction, 16 fraction bits
        logic [63:0] osc_full;      // oscillator frequency
        logic [63:0] band_full;     // after band divider
        logic [63:0] step_full;     // channel step
        logic [63:0] off_full;      // channel offset
        xtal_scaled = '0;
        cmp_full    = '0;
        mult_full   = '0;
        osc_full    = '0;
        band_full   = '0;
        step_full   = '0;
        off_full    = '0;
        d = q;

        // start bits self clear on completion; a host write in the same cycle wins
        d.start = q.start & ~done;
        if (wr_hit(i_reg_wr, i_reg_addr, `ADDR_CAL_START_CTRL)) begin
            d.start = {i_reg_wdata[`BIT_CUR_START], i_reg_wdata[`BIT_BAND_START],
                       i_reg_wdata[`BIT_DEV_START]};
        end
        if (wr_hit(i_reg_wr, i_reg_addr, `ADDR_CHANNEL))      d.channel_number      = i_reg_wdata;
        if (wr_hit(i_reg_wr, i_reg_addr, `ADDR_PLL_CTRL))     d.pll_ctrl = i_reg_wdata;
        if (wr_hit(i_reg_wr, i_reg_addr, `ADDR_INT_MULT_LO))  d.int_lo   = i_reg_wdata;
        if (wr_hit(i_reg_wr, i_reg_addr, `ADDR_FRAC_HI))      d.frac_hi  = i_reg_wdata;
        if (wr_hit(i_reg_wr, i_reg_addr, `ADDR_FRAC_LO))      d.frac_lo  = i_reg_wdata;
        if (wr_hit(i_reg_wr, i_reg_addr, `ADDR_BAND_SEL))     d.band_reg = i_reg_wdata;
        if (wr_hit(i_reg_wr, i_reg_addr, `ADDR_OSC_CUR_CAL))  d.cur_reg  = i_reg_wdata[5:0];
        if (wr_hit(i_reg_wr, i_reg_addr, `ADDR_OSC_BAND_CAL))
            d.bank_reg = {i_reg_wdata[7:5], i_reg_wdata[3:0]};
        if (wr_hit(i_reg_wr, i_reg_addr, `ADDR_OSC_DEV_CAL))  d.dev_reg  = i_reg_wdata;

        // strobes: pll and tx keep the synthesiser powered, standby, sleep and idle stop it, other nibbles leave it
        if (i_strobe_valid) begin
            case (i_strobe_cmd[7:4])
                `STROBE_PLL, `STROBE_TX: d.pll_on = 1'b1;
                `STROBE_STANDBY, `STROBE_SLEEP, `STROBE_IDLE: d.pll_on = 1'b0;
                default: d.pll_on = q.pll_on;
            endcase
        end

        // read data is captured on the read strobe; unmapped offsets read zero
        if (i_reg_rd) begin
            case (i_reg_addr)
                `ADDR_CAL_START_CTRL: d.rdata = {3'b000, q.start, 2'b00};
                `ADDR_CHANNEL:        d.rdata = q.channel_number;
                `ADDR_PLL_CTRL:       d.rdata = q.pll_ctrl;
                `ADDR_INT_MULT_LO:    d.rdata = q.int_lo;
                `ADDR_FRAC_HI:        d.rdata = q.frac_hi;
                `ADDR_FRAC_LO:        d.rdata = q.frac_lo;
                `ADDR_BAND_SEL:       d.rdata = q.band_reg;
                `ADDR_OSC_CUR_CAL:    d.rdata = {3'b000, cur_fail, cur_res};
                `ADDR_OSC_BAND_CAL:   d.rdata = {4'h0, band_fail, band_res};
                `ADDR_OSC_DEV_CAL:    d.rdata = dev_res;
                default:              d.rdata = 8'h00;
            endcase
        end

        // trims to the oscillator: engine trials while busy, else manual or result
        if (busy) begin
            d.vco_cur  = cur_trial;
            d.vco_bank = band_trial;
            d.vco_dev  = dev_trial;
        end else begin
            d.vco_cur  = q.cur_reg[`POS_MANUAL_SEL_CUR] ? q.cur_reg[3:0] : cur_res;
            d.vco_bank = q.bank_reg[`POS_MANUAL_SEL_BAND] ? q.bank_reg[2:0] : band_res;
            d.vco_dev  = q.dev_reg[`POS_MANUAL_SEL_DEV] ? {1'b0, q.dev_reg[6:0]} : dev_res;
        end

        // frequency words in hertz; the arithmetic is one registered stage deep
        xtal_scaled = 64'(XTAL_HZ) * (64'(q.pll_ctrl[`POS_REF_DOUBLER]) + 64'd1);
        cmp_full    = xtal_scaled /
                      (64'(q.pll_ctrl[`POS_REF_DIV_HI:`POS_REF_DIV_LO]) + 64'd1);
        mult_full   = {39'h0, q.pll_ctrl[0], q.int_lo, q.frac_hi, q.frac_lo};
        osc_full    = (cmp_full * mult_full) >> `FRAC_BITS;
        band_full   = osc_full /
                      band_factor(q.band_reg[`POS_BAND_SEL_HI:`POS_BAND_SEL_LO]);
        step_full   = cmp_full / (`STEP_PRESCALE *
                      (64'(q.pll_ctrl[`POS_STEP_RES_HI:`POS_STEP_RES_LO]) + 64'd1));
        off_full    = 64'(q.channel_number) * step_full;
        d.cmp     = cmp_full[31:0];
        d.base    = osc_full[31:0];
        d.band    = band_full[31:0];
        d.step    = step_full[31:0];
        d.carrier = 32'(band_full + off_full);
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q          <= '0;
            q.pll_ctrl <= `RST_PLL_CTRL;
            q.cur_reg  <= `RST_OSC_CUR_CAL;
            q.bank_reg <= `RST_OSC_BAND_CAL;
            q.dev_reg  <= `RST_OSC_DEV_CAL;
        end else begin
            q <= d;
        end
    end

    assign o_reg_rdata       = q.rdata;
    assign o_pll_on          = q.pll_on;
    assign o_cal_busy        = busy;
    assign o_vco_current     = q.vco_cur;
    assign o_vco_bank        = q.vco_bank;
    assign o_vco_dev         = q.vco_dev;
    assign o_comparison_freq = q.cmp;
    assign o_base_osc_freq   = q.base;
    assign o_band_freq       = q.band;
    assign o_channel_step    = q.step;
    assign o_carrier_freq    = q.carrier;
endmodule
`default_nettype wire

// >>> synth_ctrl_monitor.sv
// port checks of the synthesiser control block.
// assumes it is bound to synth_ctrl and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module synth_ctrl_monitor #(
    parameter int CUR_SETTLE  = 4,
    parameter int BAND_SETTLE = 8,
    parameter int DEV_SETTLE  = 4
) (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        i_strobe_valid,
    input wire logic [7:0]  i_strobe_cmd,
    input wire logic        o_pll_on,
    input wire logic        o_cal_busy,
    input wire logic [31:0] o_base_osc_freq,
    input wire logic [31:0] o_band_freq,
    input wire logic [31:0] o_channel_step,
    input wire logic [31:0] o_carrier_freq
);
    // longest full run plus slack; a stuck engine overruns it
    localparam int BUSY_MAX = 16 * CUR_SETTLE + 4 * BAND_SETTLE + 8 * DEV_SETTLE + 16;
    logic [31:0] busy_q; // cycles spent busy, wide enough for default settles
    logic [3:0]  nib;    // strobe upper nibble
    assign nib = i_strobe_cmd[7:4];
    // busy run length
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !o_cal_busy) begin
            busy_q <= 32'h0000_0000;
        end else begin
            busy_q <= busy_q + 32'h0000_0001;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    pll_enter_a: assert property (
        i_strobe_valid && nib inside {4'hB, 4'hD} |=> o_pll_on) else $error("pll not on");
    pll_leave_a: assert property (
        i_strobe_valid && nib inside {4'hA, 4'h8, 4'h9} |=> !o_pll_on) else $error("pll not off");
    pll_keep_a: assert property (
        !(i_strobe_valid && nib inside {4'h8, 4'h9, 4'hA, 4'hB, 4'hD}) |=> $stable(o_pll_on))
        else $error("pll changed alone");
    cal_needs_pll_a: assert property (
        !o_pll_on [*3] |-> !o_cal_busy) else $error("busy without pll");
    cal_bound_a: assert property (
        busy_q <= 32'(BUSY_MAX)) else $error("calibration overran");
    ctrl_read_a: assert property (
        i_reg_rd && i_reg_addr == 8'h02 |=> o_reg_rdata[7:5] == 3'b000 && o_reg_rdata[1:0] == 2'b00)
        else $error("control read shape");
    cur_read_a: assert property (
        i_reg_rd && i_reg_addr == 8'h1E |=> o_reg_rdata[7:5] == 3'b000) else $error("cur read");
    band_read_a: assert property (
        i_reg_rd && i_reg_addr == 8'h1F |=> o_reg_rdata[7:4] == 4'h0) else $error("band read");
    band_div_a: assert property (
        !i_reg_wr [*8] |-> o_band_freq inside {o_base_osc_freq / 2, o_base_osc_freq / 4,
        o_base_osc_freq / 6}) else $error("band factor");
    carrier_a: assert property (
        !i_reg_wr [*8] |-> o_channel_step == 0 || (o_carrier_freq - o_band_freq)
        % o_channel_step == 0) else $error("carrier offset");
endmodule
bind synth_ctrl synth_ctrl_monitor #(.CUR_SETTLE(CUR_SETTLE), .BAND_SETTLE(BAND_SETTLE),
    .DEV_SETTLE(DEV_SETTLE)) mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
    .i_strobe_valid(i_strobe_valid), .i_strobe_cmd(i_strobe_cmd), .o_pll_on(o_pll_on),
    .o_cal_busy(o_cal_busy), .o_base_osc_freq(o_base_osc_freq), .o_band_freq(o_band_freq),
    .o_channel_step(o_channel_step), .o_carrier_freq(o_carrier_freq));
`default_nettype wire

// >>> synth_defs.svh
// named offsets, field positions, reset values and timing figures of the
// synthesiser tuning and oscillator calibration block.
// assumes i_clk runs at the period set here as CLK_PERIOD_NS.
`ifndef SYNTH_DEFS_SVH
`define SYNTH_DEFS_SVH

// register offsets
`define ADDR_CAL_START_CTRL 8'h02
`define ADDR_CHANNEL        8'h0D
`define ADDR_PLL_CTRL       8'h0E
`define ADDR_INT_MULT_LO    8'h0F
`define ADDR_FRAC_HI        8'h10
`define ADDR_FRAC_LO        8'h11
`define ADDR_BAND_SEL       8'h2A
`define ADDR_OSC_CUR_CAL    8'h1E
`define ADDR_OSC_BAND_CAL   8'h1F
`define ADDR_OSC_DEV_CAL    8'h21

// reset values
`define RST_PLL_CTRL        8'h2E
`define RST_OSC_CUR_CAL     6'h2C
`define RST_OSC_BAND_CAL    7'h64
`define RST_OSC_DEV_CAL     8'h28

// calibration start bit positions in cal_start_ctrl
`define BIT_CUR_START       4
`define BIT_BAND_START      3
`define BIT_DEV_START       2

// field positions
`define POS_REF_DOUBLER     7
`define POS_REF_DIV_HI      6
`define POS_REF_DIV_LO      5
`define POS_STEP_RES_HI     4
`define POS_STEP_RES_LO     1
`define POS_BAND_SEL_HI     5
`define POS_BAND_SEL_LO     4
`define POS_MANUAL_SEL_CUR  4
`define POS_MANUAL_SEL_BAND 3
`define POS_MANUAL_SEL_DEV  7
`define FRAC_BITS           16

// strobe commands: upper nibble
`define STROBE_PLL          4'hB
`define STROBE_TX           4'hD
`define STROBE_STANDBY      4'hA
`define STROBE_SLEEP        4'h8
`define STROBE_IDLE         4'h9

// band division factors
`define BAND_FACTOR_HI      64'd2
`define BAND_FACTOR_MID     64'd4
`define BAND_FACTOR_LO      64'd6

// channel step = comparison frequency / (STEP_PRESCALE * (step_resolution + 1))
`define STEP_PRESCALE       64'd8

// deviation target seen by the analog deviation comparator
`define DEV_TARGET_KHZ      500

// timing
`define CLK_PERIOD_NS       5
`define PLL_SETTLE_US       60
`define CUR_SETTLE_US       5
`define DEV_SETTLE_US       5
`define US_TO_CYCLES(us)    ((us) * 1000 / `CLK_PERIOD_NS)

`define CUR_MAX             4'hF
`define BAND_LAST_STEP      3'd3
`define DEV_LAST_STEP       3'd7

`endif

// >>> synth_pkg.sv
// types shared by the synthesiser control block and its calibration engine.
// assumes nothing of its surroundings.
`default_nettype none
package synth_pkg;

    // calibration engine states, one-hot
    typedef enum logic [3:0] {
        CAL_IDLE = 4'b0001,
        CAL_CUR  = 4'b0010,
        CAL_BAND = 4'b0100,
        CAL_DEV  = 4'b1000
    } cal_fsm_type;

    // whole state of the calibration engine
    typedef struct packed {
        cal_fsm_type state;
        logic [15:0] cnt;
        logic [2:0]  step;
        logic [3:0]  cur;
        logic [2:0]  band;
        logic [7:0]  dev;
        logic [3:0]  cur_res;
        logic        cur_fail;
        logic [2:0]  band_res;
        logic        band_fail;
        logic [7:0]  dev_res;
        logic [2:0]  done;
    } cal_state_type;

    // whole state of the control block
    typedef struct packed {
        logic [2:0]  start;
        logic        pll_on;
        logic [7:0]  channel_number;
        logic [7:0]  pll_ctrl;
        logic [7:0]  int_lo;
        logic [7:0]  frac_hi;
        logic [7:0]  frac_lo;
        logic [7:0]  band_reg;
        logic [5:0]  cur_reg;
        logic [6:0]  bank_reg;
        logic [7:0]  dev_reg;
        logic [7:0]  rdata;
        logic [3:0]  vco_cur;
        logic [2:0]  vco_bank;
        logic [7:0]  vco_dev;
        logic [31:0] cmp;
        logic [31:0] base;
        logic [31:0] band;
        logic [31:0] step;
        logic [31:0] carrier;
    } ctrl_state_type;

endpackage
`default_nettype wire

// >>> tb_top.sv
// register-level bench of the synthesiser control block.
// assumes the oscillator model converges on current 9, bank 5, deviation 5a.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, sv = 1'b0;
    logic lock = 1'b1, amp, fh, pl, dh, pll, busy;
    logic [7:0] ad = 8'h00, wd = 8'h00, sc = 8'h00, rdat, vd;
    logic [3:0] vc;
    logic [2:0] vb;
    logic [31:0] cmp, base, bandf, step, car, b32;
    logic [63:0] b64; // undivided oscillator, worked out here
    int n_mismatch = 0, tests_run = 0, cyc;
    logic [7:0] cmds [6] = '{8'hB0, 8'h90, 8'hD0, 8'hE0, 8'hA0, 8'h8F};
    logic [0:5] pexp = 6'b101100; // pll state after each command
    synth_ctrl #(.XTAL_HZ(16000000), .CUR_SETTLE(4), .BAND_SETTLE(8), .DEV_SETTLE(4)) dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(ad), .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_strobe_valid(sv),
        .i_strobe_cmd(sc), .i_amp_ok(amp), .i_freq_high(fh), .i_pll_lock(pl), .i_dev_high(dh),
        .o_pll_on(pll), .o_cal_busy(busy), .o_vco_current(vc), .o_vco_bank(vb), .o_vco_dev(vd),
        .o_comparison_freq(cmp), .o_base_osc_freq(base), .o_band_freq(bandf),
        .o_channel_step(step), .o_carrier_freq(car));
    osc_analog_model osc (.i_lock_en(lock), .i_cur(vc), .i_bank(vb), .i_dev(vd),
        .o_amp_ok(amp), .o_freq_high(fh), .o_pll_lock(pl), .o_dev_high(dh));
    always #2.5 i_clk = ~i_clk;
    task automatic conclude;
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // every request is raised after a falling edge and held over one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ad = a;
        wd = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
        @(negedge i_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        ad = a;
        i_reg_rd = 1'b1;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        chk(32'(rdat), 32'(e));
        @(negedge i_clk);
    endtask
    task automatic strobe(input logic [7:0] c);
        sc = c;
        sv = 1'b1;
        @(negedge i_clk);
        sv = 1'b0;
        @(negedge i_clk);
    endtask
    // bounded wait; busy drops for one cycle between items, so ask for three
    task automatic wait_idle;
        int idle;
        idle = 0;
        cyc = 0;
        do begin
            @(negedge i_clk);
            cyc++;
            idle = (busy === 1'b0) ? idle + 1 : 0;
        end while (idle < 3 && cyc < 400);
        if (idle < 3)
            n_mismatch++;
    endtask
    initial begin
        repeat (8) @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_clk);
        chk(32'(vd), 32'h0000_0028);
        rd(8'h0E, 8'h2E);
        rd(8'h55, 8'h00);
        foreach (cmds[i]) begin
            strobe(cmds[i]);
            chk(32'(pll), 32'(pexp[i]));
        end
        wr(8'h0E, 8'h0E);
        wr(8'h0F, 8'h70);
        wr(8'h10, 8'h80);
        wr(8'h11, 8'h08);
        wr(8'h0D, 8'h3C);
        b64 = (64'h0000_0000_00F4_2400 * 64'h0000_0000_0070_8008) >> 16;
        for (int m = 0; m < 4; m++) begin
            wr(8'h2A, 8'(m << 4));
            repeat (8) @(negedge i_clk);
            chk(base, b64[31:0]);
            b32 = 32'(b64 / ((m == 0) ? 6 : (m == 1) ? 4 : 2));
            chk(bandf, b32);
            chk(car, b32 + 32'h0000_003C * 32'h0003_D090);
        end
        chk(cmp, 32'h00F4_2400);
        chk(step, 32'h0003_D090);
        strobe(8'hB0);
        wr(8'h02, 8'h1C);
        wait_idle;
        rd(8'h02, 8'h00);
        rd(8'h1E, 8'h09);
        rd(8'h1F, 8'h05);
        rd(8'h21, 8'h5A);
        chk({vc, 1'b0, vb, vd}, 32'h0000_955A);
        lock = 1'b0;
        wr(8'h02, 8'h08);
        wait_idle;
        chk(32'(cyc <= 40), 32'h0000_0001);
        rd(8'h1F, 8'h0D);
        wr(8'h1E, 8'h37);
        wr(8'h1F, 8'hCE);
        wr(8'h21, 8'hB3);
        repeat (3) @(negedge i_clk);
        chk({vc, 1'b0, vb, vd}, 32'h0000_7633);
        conclude;
    end
    initial begin
        #50000;
        n_mismatch++;
        conclude;
    end
endmodule
`default_nettype wire
